// File: design/bscrm_boot_select.v
// Boot selection at reset release plus the code-read map decoder.
// Assumes strap pins are synchronous to sys_clk_i and stable at release.
`timescale 1ns/10ps
`default_nettype none
`include "bscrm_defs.vh"

module bscrm_boot_select (
	input  wire        sys_clk_i,          // Core clock, 25 MHz
	input  wire        resetn_i,           // Sync reset, active low
	input  wire        strobe_pin_i,       // Program store strobe pin level
	output wire        strobe_pin_o,       // Strobe pin drive value
	output wire        strobe_pin_oe_o,    // Strobe pin drive enable
	input  wire        ext_access_pin_i,   // External access pin level
	input  wire        addr_latch_pin_i,   // Address latch pin (pulled high)
	input  wire        nv_jump_valid_i,    // Stored jump bit programmed
	input  wire        nv_jump_i,          // Stored loader jump select
	input  wire [7:0]  nv_vector_i,        // Stored user loader vector
	input  wire        strobe_run_i,       // Core strobe value after boot
	input  wire        flash_control_reg_we_i,          // Core writes flash control
	input  wire [7:0]  flash_control_reg_wdata_i,       // Flash control write data
	input  wire        boot_en_we_i,       // Core writes boot enable
	input  wire        boot_en_wdata_i,    // Boot enable write data
	input  wire        rd_req_i,           // Code read request
	input  wire [15:0] rd_addr_i,          // Code read address
	input  wire        exec_boot_i,        // Executing from boot flash
	input  wire        rollover_i,         // Execution rolled over
	output reg  [15:0] start_pc_o,         // Start address for the core
	output reg         start_valid_o,      // Start address loaded pulse
	output reg  [7:0]  flash_control_reg_o,// Flash control register
	output reg         boot_space_enable_o,// Boot space enable bit
	output reg         hw_boot_o,          // Hardware boot was taken
	output reg         loader_jump_select_o,// Jump bit as sampled
	output reg         user_loader_present_o,// User loader vector set
	output reg  [15:0] user_loader_addr_o, // User loader start address
	output wire        flash_page_select_o,// Page select bit
	output wire [2:0]  rd_target_o,        // Code read space
	output wire [15:0] rd_space_addr_o,    // Address in that space
	output wire        rd_valid_o          // Code read result valid
);

	reg         in_reset;
	reg         ext_exec;
	wire        hw_cond;
	wire        jump_bit;

	// Erased or unprogrammed storage reads as the shipped value
	assign jump_bit = nv_jump_valid_i ? nv_jump_i
		: `BSCRM_JUMP_SHIPPED;

	// Straps are sampled only on the cycle reset is released; the board
	// is free to change them at any other time while reset is low.
	assign hw_cond = !strobe_pin_i && ext_access_pin_i
		&& addr_latch_pin_i;

	// Pin stays undriven during reset so the board can pull it low.
	assign strobe_pin_o = strobe_run_i;
	assign strobe_pin_oe_o = !in_reset;
	assign flash_page_select_o = flash_control_reg_o[`BSCRM_FPS_BIT];

	always @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			in_reset <= 1'b1;
			start_pc_o <= `BSCRM_PC_USER;
			start_valid_o <= 1'b0;
			flash_control_reg_o <= `BSCRM_FLASH_CONTROL_REG_NORMAL;
			boot_space_enable_o <= 1'b0;
			hw_boot_o <= 1'b0;
			loader_jump_select_o <= 1'b0;
			user_loader_present_o <= 1'b0;
			user_loader_addr_o <= `BSCRM_ADDR_ZERO;
			ext_exec <= 1'b0;
		end else if (in_reset) begin
			// First clocked cycle after release acts as the falling edge
			in_reset <= 1'b0;
			start_valid_o <= 1'b1;
			boot_space_enable_o <= jump_bit;
			loader_jump_select_o <= jump_bit;
			hw_boot_o <= hw_cond;
			ext_exec <= !ext_access_pin_i;
			user_loader_present_o <= (nv_vector_i != `BSCRM_VEC_NONE);
			user_loader_addr_o <= {nv_vector_i, `BSCRM_VEC_LOW};
			if (hw_cond) begin
				flash_control_reg_o <= `BSCRM_FLASH_CONTROL_REG_HWBOOT;
				start_pc_o <= `BSCRM_PC_BOOT;
			end else begin
				flash_control_reg_o <= `BSCRM_FLASH_CONTROL_REG_NORMAL;
				if (jump_bit)
					start_pc_o <= `BSCRM_PC_USER;
				else
					start_pc_o <= `BSCRM_PC_BOOT;
			end
		end else begin
			start_valid_o <= 1'b0;
			if (flash_control_reg_we_i)
				flash_control_reg_o <= flash_control_reg_wdata_i;
			if (boot_en_we_i)
				boot_space_enable_o <= boot_en_wdata_i;
		end
	end

	bscrm_code_map u_map (
		.sys_clk_i       (sys_clk_i),
		.resetn_i        (resetn_i),
		.rd_req_i        (rd_req_i),
		.rd_addr_i       (rd_addr_i),
		.exec_boot_i     (exec_boot_i),
		.exec_ext_i      (ext_exec || rollover_i),
		.flash_control_reg_i          (flash_control_reg_o),
		.boot_en_i       (boot_space_enable_o),
		.rd_target_o     (rd_target_o),
		.rd_space_addr_o (rd_space_addr_o),
		.rd_valid_o      (rd_valid_o)
	);

endmodule

`default_nettype wire

// File: common/bscrm_defs.vh
// Constants for the boot selection and code-read map block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef BSCRM_DEFS_VH
`define BSCRM_DEFS_VH

`define BSCRM_FLASH_CONTROL_REG_HWBOOT     8'h00
`define BSCRM_FLASH_CONTROL_REG_NORMAL     8'hF0
`define BSCRM_PC_BOOT         16'hF800
`define BSCRM_PC_USER         16'h0000
`define BSCRM_BOOT_BASE       16'hF800
`define BSCRM_EXTRA_FLASH_ROW_MASK       16'h007F
`define BSCRM_VEC_NONE        8'hFF
`define BSCRM_VEC_LOW         8'h00
`define BSCRM_ADDR_ZERO       16'h0000
`define BSCRM_JUMP_SHIPPED    1'b0
`define BSCRM_FMOD_HI_BIT     7
`define BSCRM_FMOD_LO_BIT     6
`define BSCRM_FPS_BIT         3
`define BSCRM_MODE_USER       2'h0
`define BSCRM_MODE_EXTRA_FLASH_ROW       2'h1
`define BSCRM_MODE_HWBYTE     2'h2
`define BSCRM_MODE_ALT        2'h3

// Target space codes on the code-read decoder output
`define BSCRM_TGT_NONE        3'h0
`define BSCRM_TGT_USER        3'h1
`define BSCRM_TGT_BOOT        3'h2
`define BSCRM_TGT_EXTRA_FLASH_ROW        3'h3
`define BSCRM_TGT_HWBYTE      3'h4
`define BSCRM_TGT_EXT         3'h5
`define BSCRM_TGT_AVOID       3'h6

`endif

// File: design/bscrm_code_map.v
// Code-read space decoder: routes a constant-read address to a space.
// Assumes flash control and boot enable come from registered state.
`timescale 1ns/10ps
`default_nettype none
`include "bscrm_defs.vh"

module bscrm_code_map (
	input  wire        sys_clk_i,          // Core clock
	input  wire        resetn_i,           // Sync reset, active low
	input  wire        rd_req_i,           // Code read request
	input  wire [15:0] rd_addr_i,          // Data pointer address
	input  wire        exec_boot_i,        // Executing from boot flash
	input  wire        exec_ext_i,         // Executing externally
	input  wire [7:0]  flash_control_reg_i,             // Flash control register
	input  wire        boot_en_i,          // Boot space enable
	output reg  [2:0]  rd_target_o,        // Selected space
	output reg  [15:0] rd_space_addr_o,    // Address inside that space
	output reg         rd_valid_o          // Decode result valid
);

	reg  [2:0]  next_target;
	reg  [15:0] next_addr;
	wire [1:0]  mode;
	wire        hi_half;

	assign mode = {flash_control_reg_i[`BSCRM_FMOD_HI_BIT], flash_control_reg_i[`BSCRM_FMOD_LO_BIT]};
	assign hi_half = (rd_addr_i >= `BSCRM_BOOT_BASE);

	always @* begin
		next_target = `BSCRM_TGT_NONE;
		next_addr = rd_addr_i;
		if (exec_ext_i) begin
			// Only mode field low bit clear decodes externally
			if (!flash_control_reg_i[`BSCRM_FMOD_LO_BIT])
				next_target = `BSCRM_TGT_EXT;
		end else if (!exec_boot_i) begin
			case (mode)
			`BSCRM_MODE_USER, `BSCRM_MODE_ALT: begin
				if (boot_en_i && hi_half)
					next_target = `BSCRM_TGT_AVOID;
				else
					next_target = `BSCRM_TGT_USER;
			end
			`BSCRM_MODE_EXTRA_FLASH_ROW: begin
				next_target = `BSCRM_TGT_EXTRA_FLASH_ROW;
				next_addr = rd_addr_i & `BSCRM_EXTRA_FLASH_ROW_MASK;
			end
			`BSCRM_MODE_HWBYTE: begin
				next_target = `BSCRM_TGT_HWBYTE;
			end
			default: begin
				next_target = `BSCRM_TGT_NONE;
			end
			endcase
		end else if (boot_en_i) begin
			case (mode)
			`BSCRM_MODE_USER: begin
				if (hi_half)
					next_target = `BSCRM_TGT_BOOT;
				else
					next_target = `BSCRM_TGT_USER;
			end
			`BSCRM_MODE_EXTRA_FLASH_ROW: begin
				next_target = `BSCRM_TGT_EXTRA_FLASH_ROW;
				next_addr = rd_addr_i & `BSCRM_EXTRA_FLASH_ROW_MASK;
			end
			`BSCRM_MODE_HWBYTE: begin
				next_target = `BSCRM_TGT_HWBYTE;
			end
			`BSCRM_MODE_ALT: begin
				next_target = `BSCRM_TGT_USER;
			end
			default: begin
				next_target = `BSCRM_TGT_NONE;
			end
			endcase
		end else begin
			// Boot execution without enable: no space available
			next_target = `BSCRM_TGT_NONE;
		end
	end

	always @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			rd_target_o <= `BSCRM_TGT_NONE;
			rd_space_addr_o <= `BSCRM_ADDR_ZERO;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= rd_req_i;
			if (rd_req_i) begin
				rd_target_o <= next_target;
				rd_space_addr_o <= next_addr;
			end
		end
	end

endmodule

`default_nettype wire

// File: sim/bscrm_checker.sv
// Checker for boot result and code-read timing on the top ports.
// Assumes one clock domain and a bind onto bscrm_boot_select.
`timescale 1ns/10ps
`default_nettype none
module bscrm_checker (
	input wire logic        sys_clk_i,            // Clock
	input wire logic        resetn_i,             // Reset
	input wire logic        rd_req_i,             // Read request
	input wire logic        start_valid_o,        // Boot pulse
	input wire logic        hw_boot_o,            // Hw boot
	input wire logic        loader_jump_select_o, // Jump bit
	input wire logic        boot_space_enable_o,  // Boot enable
	input wire logic [15:0] start_pc_o,           // Start address
	input wire logic [7:0]  flash_control_reg_o,  // Flash control
	input wire logic        rd_valid_o,           // Read valid
	input wire logic [2:0]  rd_target_o,          // Read space
	input wire logic [15:0] rd_space_addr_o       // Space address
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_read;
		rd_req_i ##1 rd_valid_o;
	endsequence
	a_read_answer: assert property (rd_req_i |-> s_read)
		else $error("read not answered");
	a_no_stray_read: assert property (
		!rd_req_i |=> !rd_valid_o)
		else $error("stray read valid");
	a_start_pulse: assert property (
		start_valid_o |=> !start_valid_o)
		else $error("start pulse too long");
	a_hw_boot_ctl: assert property (
		start_valid_o && hw_boot_o |-> flash_control_reg_o == 8'h00)
		else $error("hw boot flash control");
	a_hw_boot_pc: assert property (
		start_valid_o && hw_boot_o |-> start_pc_o == 16'hF800)
		else $error("hw boot start address");
	a_norm_ctl: assert property (
		start_valid_o && !hw_boot_o |-> flash_control_reg_o == 8'hF0)
		else $error("normal flash control");
	a_norm_pc: assert property (
		start_valid_o && !hw_boot_o |->
		start_pc_o == (loader_jump_select_o ? 16'h0000 : 16'hF800))
		else $error("normal start address");
	a_enable_jump: assert property (
		start_valid_o |-> boot_space_enable_o == loader_jump_select_o)
		else $error("boot enable not jump bit");
	a_extra_flash_row_alias: assert property (
		rd_valid_o && rd_target_o == 3'h3 |-> rd_space_addr_o[15:7] == 9'h000)
		else $error("extra row alias");
endmodule
bind bscrm_boot_select bscrm_checker u_chk (.sys_clk_i(sys_clk_i),
	.resetn_i(resetn_i), .rd_req_i(rd_req_i), .start_valid_o(start_valid_o),
	.hw_boot_o(hw_boot_o), .loader_jump_select_o(loader_jump_select_o),
	.boot_space_enable_o(boot_space_enable_o), .start_pc_o(start_pc_o),
	.flash_control_reg_o(flash_control_reg_o), .rd_valid_o(rd_valid_o),
	.rd_target_o(rd_target_o), .rd_space_addr_o(rd_space_addr_o));
`default_nettype wire

// File: sim/bscrm_board.sv
// Board model: reset circuit and strobe strap with pull-up.
// Assumes the bench asks for reset and the strap level synchronously.
`timescale 1ns/10ps
`default_nettype none
module bscrm_board (
	input  wire logic sys_clk_i,   // Clock
	input  wire logic rst_req_i,   // Bench wants reset
	input  wire logic hw_strap_i,  // Pull strobe pin low
	input  wire logic dev_oe_i,    // Device drives pin
	input  wire logic dev_lvl_i,   // Device pin value
	output var  logic resetn_o,    // Reset to device
	output wire logic strobe_lvl_o // Resolved pin level
);
	logic hold;
	initial resetn_o = 1'b0;
	initial hold = 1'b1;
	// Strap stays valid through the release edge, then lets go
	always @(posedge sys_clk_i) begin
		resetn_o <= !rst_req_i;
		hold     <= !resetn_o;
	end
	// Released pin floats to its pull-up unless the device drives it
	assign strobe_lvl_o = hold ? !hw_strap_i
		: (dev_oe_i ? dev_lvl_i : 1'b1);
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench: boot choices and code-read decode.
// Assumes the board model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; \
	if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t %s", $time, m); end end
module tb_top;
	logic sys_clk_i = 1'b0, rst_req = 1'b1, strap = 1'b0, ext = 1'b1, lat = 1'b1;
	logic nvv = 1'b0, nvj = 1'b0, srun = 1'b1, fwe = 1'b0, bwe = 1'b0, bwd = 1'b0;
	logic rreq = 1'b0, xboot = 1'b0, roll = 1'b0;
	logic [7:0] vec = 8'hFF, fwd = 8'h00;
	logic [15:0] raddr = 16'h0000;
	wire resetn, lvl, spo, oe, sv, en, hwb, ljs, ulp, flash_page_select, rv;
	wire [15:0] pc, ula, sad;
	wire [7:0] flash_control_reg;
	wire [2:0] tgt;
	int error_cnt = 0, num_checks = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	bscrm_board board (.sys_clk_i(sys_clk_i), .rst_req_i(rst_req),
		.hw_strap_i(strap), .dev_oe_i(oe), .dev_lvl_i(spo),
		.resetn_o(resetn), .strobe_lvl_o(lvl));
	bscrm_boot_select DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn),
		.strobe_pin_i(lvl), .strobe_pin_o(spo), .strobe_pin_oe_o(oe),
		.ext_access_pin_i(ext), .addr_latch_pin_i(lat), .nv_jump_valid_i(nvv),
		.nv_jump_i(nvj), .nv_vector_i(vec), .strobe_run_i(srun),
		.flash_control_reg_we_i(fwe), .flash_control_reg_wdata_i(fwd), .boot_en_we_i(bwe),
		.boot_en_wdata_i(bwd), .rd_req_i(rreq), .rd_addr_i(raddr),
		.exec_boot_i(xboot), .rollover_i(roll), .start_pc_o(pc),
		.start_valid_o(sv), .flash_control_reg_o(flash_control_reg),
		.boot_space_enable_o(en), .hw_boot_o(hwb), .loader_jump_select_o(ljs),
		.user_loader_present_o(ulp), .user_loader_addr_o(ula),
		.flash_page_select_o(flash_page_select), .rd_target_o(tgt),
		.rd_space_addr_o(sad), .rd_valid_o(rv));
	function automatic logic [2:0] dec(input logic x, input logic [15:0] a);
		logic [1:0] m;
		m = fwd[7:6];
		if (x) return m[0] ? 3'h0 : 3'h5;
		if (!xboot) return m == 2'h1 ? 3'h3 : m == 2'h2 ? 3'h4 :
			(bwd && a >= 16'hF800) ? 3'h6 : 3'h1;
		if (!bwd) return 3'h0;
		return m == 2'h1 ? 3'h3 : m == 2'h2 ? 3'h4 :
			(m == 2'h0 && a >= 16'hF800) ? 3'h2 : 3'h1;
	endfunction
	task automatic boot(input logic [4:0] c);
		logic hw, j, x;
		logic [2:0] t;
		int k;
		@(posedge sys_clk_i);
		{nvv, nvj, lat, ext, strap} <= c;
		rst_req <= 1'b1;
		vec <= (c == 5'h05) ? 8'hFF : 8'($urandom);
		repeat (3) @(posedge sys_clk_i);
		rst_req <= 1'b0;
		// Writes held across the release edge must not touch the boot result
		{fwe, bwe} <= 2'b11;
		k = 0;
		@(negedge sys_clk_i);
		`CHK(oe, 1'b0, "pin driven in reset")
		do begin @(negedge sys_clk_i); k++; end while (sv !== 1'b1 && k < 10);
		hw = c[0] & c[1] & c[2];
		j = c[4] & c[3];
		`CHK(sv, 1'b1, "no start pulse")
		`CHK(hwb, hw, "hw boot")
		`CHK(pc, (hw || !j) ? 16'hF800 : 16'h0000, "start address")
		`CHK(flash_control_reg, hw ? 8'h00 : 8'hF0, "flash control")
		`CHK(en, j, "boot enable")
		`CHK(ljs, j, "jump fallback")
		`CHK({ulp, ula}, {vec != 8'hFF, vec, 8'h00}, "loader vector")
		`CHK({oe, spo}, {1'b1, srun}, "pin drive after boot")
		repeat (6) begin
			@(posedge sys_clk_i);
			{fwe, bwe, fwd, bwd, srun} <= {2'b11, 8'($urandom), 2'($urandom)};
			@(posedge sys_clk_i);
			{fwe, bwe, rreq, raddr} <= {3'b001, 16'($urandom)};
			{xboot, roll} <= {1'($urandom), ($urandom % 4) == 0};
			@(posedge sys_clk_i);
			rreq <= 1'b0;
			@(negedge sys_clk_i);
			x = !c[1] || roll;
			t = dec(x, raddr);
			`CHK({rv, flash_control_reg, en, flash_page_select}, {1'b1, fwd, bwd, fwd[3]}, "write")
			`CHK({oe, spo}, {1'b1, srun}, "pin drive")
			if (x) `CHK(tgt, t, "external")
			else if (xboot) `CHK(tgt, t, "boot exec")
			else `CHK(tgt, t, "user exec")
			`CHK(sad, (t == 3'h3) ? (raddr & 16'h007F) : raddr, "addr")
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h2B0C2F24));
		repeat (8) @(posedge sys_clk_i);
		for (int c = 0; c < 32; c++) boot(5'(c));
		give_verdict;
	end
	initial begin
		#200000;
		error_cnt++;
		give_verdict;
	end
endmodule
`default_nettype wire
